//--- design/pmf_mon.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pmf_mon #(
   parameter int STORE_CYC = pmf_pkg::STORE_CYC,
   parameter logic [6:0] DEV_ADDR = pmf_pkg::DEV_ADDR_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic fault_alert_line_o,
   output logic fault_alert_line_oe,
   input wire logic primary_remote_onoff_pin,
   input wire logic output_ok_indicator_i,
   output logic output_ok_indicator_o,
   output logic output_ok_indicator_oe,
   output logic output_enable,
   output logic [15:0] vout_target
);

   localparam int SCW = $clog2(STORE_CYC + 1);

   typedef struct packed {
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic [2:0] rc_sy;
      logic [2:0] sec_sy;
      logic scl_f;
      logic sda_f;
      logic rc_f;
      logic sec_f;
      pmf_pkg::pmf_pst_e pst;
      logic [3:0] bitcnt;
      logic ackp;
      logic ackw;
      logic mack;
      logic rbyte;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [7:0] cmd;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [1:0] widx;
      logic [15:0] rdw;
      logic sda_oe;
      logic [pmf_pkg::NCFG-1:0][15:0] cfg;
      logic [pmf_pkg::NCFG-1:0][15:0] usr;
      logic [pmf_pkg::NST-1:0][7:0] mask;
      logic [pmf_pkg::NST-1:0][7:0] st;
      logic busyf;
      logic alert;
      logic init_done;
      logic vin_ok;
      logic out_on;
      logic hwopt;
      logic [SCW-1:0] scnt;
      logic [6:0][15:0] tel;
      logic [15:0] vout_tgt;
      logic pg_oe;
      logic pg_o;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pmf_state_s;

   pmf_state_s r;
   pmf_state_s n;

   // ==========================================================================
   // Decoders
   function automatic logic [2:0] cfg_idx(input logic [7:0] c);
      case (c)
         pmf_pkg::CMD_ON_OFF_CONFIG: cfg_idx = pmf_pkg::CFG_ONOFF;
         pmf_pkg::CMD_VOUT_COMMAND: cfg_idx = pmf_pkg::CFG_VOUT_CMD;
         pmf_pkg::CMD_VOUT_TRIM: cfg_idx = pmf_pkg::CFG_VOUT_TRIM;
         pmf_pkg::CMD_VIN_ON: cfg_idx = pmf_pkg::CFG_VIN_ON;
         pmf_pkg::CMD_VIN_OFF: cfg_idx = pmf_pkg::CFG_VIN_OFF;
         pmf_pkg::CMD_TEMP_SOURCE: cfg_idx = pmf_pkg::CFG_TSRC;
         default: cfg_idx = pmf_pkg::IDX_NONE;
      endcase
   endfunction

   function automatic logic [2:0] stat_idx(input logic [7:0] c);
      case (c)
         pmf_pkg::CMD_STATUS_VOUT: stat_idx = 3'h0;
         pmf_pkg::CMD_STATUS_IOUT: stat_idx = 3'h1;
         pmf_pkg::CMD_STATUS_INPUT: stat_idx = 3'h2;
         pmf_pkg::CMD_STATUS_TEMP: stat_idx = 3'h3;
         pmf_pkg::CMD_STATUS_CML: stat_idx = 3'h4;
         pmf_pkg::CMD_STATUS_MFR: stat_idx = 3'h5;
         default: stat_idx = pmf_pkg::IDX_NONE;
      endcase
   endfunction

   function automatic logic cmd_known(input logic [7:0] c);
      case (c)
         pmf_pkg::CMD_CLEAR_FAULTS, pmf_pkg::CMD_STORE_DEFAULT_ALL,
         pmf_pkg::CMD_RESTORE_DEFAULT_ALL, pmf_pkg::CMD_STORE_USER_ALL,
         pmf_pkg::CMD_SMBALERT_MASK, pmf_pkg::CMD_STATUS_BYTE,
         pmf_pkg::CMD_STATUS_WORD, pmf_pkg::CMD_READ_VIN, pmf_pkg::CMD_READ_VOUT,
         pmf_pkg::CMD_READ_IOUT, pmf_pkg::CMD_READ_TEMP, pmf_pkg::CMD_READ_DUTY,
         pmf_pkg::CMD_READ_FREQ: cmd_known = 1'b1;
         default: cmd_known = (cfg_idx(c) != pmf_pkg::IDX_NONE) ||
            (stat_idx(c) != pmf_pkg::IDX_NONE);
      endcase
   endfunction

   // ==========================================================================
   // Next state
   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic clr_cmd;
      logic clr;
      logic busy_ev;
      logic apb_wr;
      logic apb_hit;
      logic rc_on;
      logic sec_on;
      logic [7:0] b;
      logic [7:0] sb;
      logic [2:0] ci;
      logic [2:0] si;
      logic [15:0] rv;
      logic [31:0] rd_apb;
      logic [pmf_pkg::NST-1:0][7:0] ev;
      n = r;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      clr_cmd = 1'b0;
      clr = 1'b0;
      busy_ev = 1'b0;
      rc_on = 1'b0;
      sec_on = 1'b0;
      b = {r.sh[6:0], r.sda_f};
      ci = cfg_idx(r.cmd);
      si = stat_idx(r.cmd);
      ev = '0;
      apb_wr = psel & penable & pwrite & r.pready;
      apb_hit = (paddr[1:0] == 2'h0) &&
         ((paddr <= pmf_pkg::A_TEL_LAST) || (paddr == pmf_pkg::A_FAULT_EVT) ||
         (paddr == pmf_pkg::A_FAULT_EVT2) || (paddr == pmf_pkg::A_HWOPT) ||
         (paddr == pmf_pkg::A_STATE));
      // Status byte summary, then the read multiplexer for the held command.
      sb = {r.busyf, ~r.out_on, r.st[0][7], r.st[1][7], r.st[2][4], |r.st[3],
         |r.st[4], |r.st[5]};
      case (r.cmd)
         pmf_pkg::CMD_READ_VIN: rv = r.tel[0];
         pmf_pkg::CMD_READ_VOUT: rv = r.tel[1];
         pmf_pkg::CMD_READ_IOUT: rv = r.tel[2];
         pmf_pkg::CMD_READ_TEMP: rv = r.cfg[pmf_pkg::CFG_TSRC][0] ? r.tel[4] : r.tel[3];
         pmf_pkg::CMD_READ_FREQ: rv = r.tel[5];
         pmf_pkg::CMD_READ_DUTY: rv = r.tel[6];
         pmf_pkg::CMD_STATUS_BYTE: rv = {8'h00, sb};
         pmf_pkg::CMD_STATUS_WORD: rv = {|r.st[0], |r.st[1], |r.st[2], |r.st[5],
            ~r.out_on, 3'h0, sb};
         default: begin
            if (si != pmf_pkg::IDX_NONE) begin
               rv = {8'h00, r.st[si]};
            end else if (ci != pmf_pkg::IDX_NONE) begin
               rv = r.cfg[ci];
            end else begin
               rv = 16'hffff;
            end
         end
      endcase
      case (paddr)
         pmf_pkg::A_HWOPT: rd_apb = {31'h0, r.hwopt};
         pmf_pkg::A_STATE: rd_apb = {26'h0, (r.scnt != '0), r.busyf, r.alert,
            r.out_on, r.vin_ok, r.init_done};
         default: rd_apb = (paddr <= pmf_pkg::A_TEL_LAST) ? {16'h0, r.tel[paddr[4:2]]} : '0;
      endcase

      if (ce) begin
         // Pin synchronisers: a level counts once the second and third stages agree.
         n.scl_sy = {r.scl_sy[1:0], scl_i};
         n.sda_sy = {r.sda_sy[1:0], sda_i};
         n.rc_sy = {r.rc_sy[1:0], primary_remote_onoff_pin};
         n.sec_sy = {r.sec_sy[1:0], output_ok_indicator_i};
         if (r.scl_sy[1] == r.scl_sy[2]) begin
            n.scl_f = r.scl_sy[2];
         end
         if (r.sda_sy[1] == r.sda_sy[2]) begin
            n.sda_f = r.sda_sy[2];
         end
         if (r.rc_sy[1] == r.rc_sy[2]) begin
            n.rc_f = r.rc_sy[2];
         end
         if (r.sec_sy[1] == r.sec_sy[2]) begin
            n.sec_f = r.sec_sy[2];
         end
         scl_rise = n.scl_f & ~r.scl_f;
         scl_fall = ~n.scl_f & r.scl_f;
         start_c = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
         stop_c = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;

         // ===================================================================
         // Register bus slave with a fixed zero-wait answer.
         n.pready = psel & ~penable;
         n.prdata = '0;
         n.pslverr = 1'b0;
         if (psel & ~penable) begin
            n.prdata = rd_apb;
            n.pslverr = ~apb_hit;
         end
         if (apb_wr && apb_hit) begin
            if (paddr <= pmf_pkg::A_TEL_LAST) begin
               n.tel[paddr[4:2]] = pwdata[15:0];
            end else if (paddr == pmf_pkg::A_FAULT_EVT) begin
               ev[3:0] = pwdata;
            end else if (paddr == pmf_pkg::A_FAULT_EVT2) begin
               ev[5] = pwdata[7:0];
            end else if (paddr == pmf_pkg::A_HWOPT) begin
               n.hwopt = pwdata[0];
            end
         end

         if (r.scnt != '0) begin
            n.scnt = r.scnt - SCW'(1);
         end

         // ===================================================================
         // Serial target.
         if (start_c) begin
            n.pst = pmf_pkg::P_ADDR;
            n.bitcnt = 4'h0;
            n.ackp = 1'b0;
            n.sda_oe = 1'b0;
         end else if (stop_c) begin
            n.pst = pmf_pkg::P_IDLE;
            n.sda_oe = 1'b0;
            n.ackp = 1'b0;
            if (r.pst == pmf_pkg::P_WR) begin
               if (r.widx == 2'h0) begin
                  case (r.cmd)
                     pmf_pkg::CMD_CLEAR_FAULTS: clr_cmd = 1'b1;
                     pmf_pkg::CMD_STORE_DEFAULT_ALL, pmf_pkg::CMD_STORE_USER_ALL: begin
                        n.usr = r.cfg;
                        n.scnt = SCW'(STORE_CYC);
                     end
                     pmf_pkg::CMD_RESTORE_DEFAULT_ALL: n.cfg = pmf_pkg::CFG_DEF;
                     default: ;
                  endcase
               end else if (ci != pmf_pkg::IDX_NONE) begin
                  n.cfg[ci] = (r.widx == 2'h2) ? {r.d1, r.d0} : {8'h00, r.d0};
               end else if ((r.cmd == pmf_pkg::CMD_SMBALERT_MASK) && (r.widx == 2'h2) &&
                  (stat_idx(r.d0) != pmf_pkg::IDX_NONE)) begin
                  n.mask[stat_idx(r.d0)] = r.d1;
               end
            end
         end else if (r.pst != pmf_pkg::P_IDLE) begin
            if (scl_rise) begin
               if (r.ackp) begin
                  n.mack = ~r.sda_f;
               end else begin
                  n.sh = b;
                  n.bitcnt = r.bitcnt + 4'h1;
                  if ((r.bitcnt == 4'h7) && (r.pst != pmf_pkg::P_RD)) begin
                     n.ackw = 1'b1;
                     case (r.pst)
                        pmf_pkg::P_ADDR: begin
                           if (b[7:1] != DEV_ADDR) begin
                              n.pst = pmf_pkg::P_IDLE;
                           end else if (r.scnt != '0) begin
                              busy_ev = 1'b1;
                              n.pst = pmf_pkg::P_IDLE;
                           end else if (b[0]) begin
                              n.pst = pmf_pkg::P_RD;
                              n.rdw = rv;
                              n.tx = rv[7:0];
                              n.rbyte = 1'b0;
                           end else begin
                              n.pst = pmf_pkg::P_CMD;
                           end
                        end
                        pmf_pkg::P_CMD: begin
                           n.cmd = b;
                           n.widx = 2'h0;
                           n.pst = pmf_pkg::P_WR;
                           ev[pmf_pkg::ST_CML][7] = ~cmd_known(b);
                        end
                        default: begin
                           if (r.widx == 2'h0) begin
                              n.d0 = b;
                           end else begin
                              n.d1 = b;
                           end
                           n.widx = (r.widx == 2'h2) ? 2'h2 : r.widx + 2'h1;
                        end
                     endcase
                  end
               end
            end else if (scl_fall) begin
               if (r.bitcnt == 4'h8) begin
                  n.bitcnt = 4'h0;
                  n.ackp = 1'b1;
                  n.sda_oe = r.ackw;
                  n.ackw = 1'b0;
               end else if (r.ackp) begin
                  n.ackp = 1'b0;
                  n.sda_oe = 1'b0;
                  if (r.pst == pmf_pkg::P_RD) begin
                     if (r.sda_oe) begin
                        n.sda_oe = ~r.tx[7];
                     end else if (r.mack) begin
                        n.tx = r.rbyte ? 8'hff : r.rdw[15:8];
                        n.rbyte = 1'b1;
                        n.sda_oe = ~n.tx[7];
                     end else begin
                        n.pst = pmf_pkg::P_IDLE;
                     end
                  end
               end else if (r.pst == pmf_pkg::P_RD) begin
                  n.sda_oe = ~r.tx[~r.bitcnt[2:0]];
               end
            end
         end

         // ===================================================================
         // Initial load of working settings from the user area.
         if (!r.init_done) begin
            n.cfg = r.usr;
            n.init_done = 1'b1;
         end

         // ===================================================================
         // Power control.
         if (r.tel[0] >= r.cfg[pmf_pkg::CFG_VIN_ON]) begin
            n.vin_ok = 1'b1;
         end else if (r.tel[0] < r.cfg[pmf_pkg::CFG_VIN_OFF]) begin
            n.vin_ok = 1'b0;
         end
         rc_on = ~r.rc_f;
         if (!r.hwopt) begin
            sec_on = 1'b1;
         end else if (r.cfg[pmf_pkg::CFG_ONOFF][pmf_pkg::ONOFF_SEC_POL_BIT]) begin
            sec_on = r.sec_f;
         end else begin
            sec_on = ~r.sec_f;
         end
         n.out_on = r.init_done & r.vin_ok & rc_on & sec_on;
         n.vout_tgt = r.cfg[pmf_pkg::CFG_VOUT_CMD] + r.cfg[pmf_pkg::CFG_VOUT_TRIM];
         n.pg_oe = ~r.hwopt;
         n.pg_o = ~r.out_on;

         // ===================================================================
         // Sticky status and alert; a new event wins over a clear.
         clr = clr_cmd | (n.out_on & ~r.out_on);
         for (int i = 0; i < pmf_pkg::NST; i++) begin
            n.st[i] = ev[i] | (r.st[i] & ~{8{clr}});
         end
         n.busyf = busy_ev | (r.busyf & ~clr);
         n.alert = (|(ev & ~r.mask)) | (r.alert & ~clr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.scl_sy <= pmf_pkg::SYNC_IDLE;
         r.sda_sy <= pmf_pkg::SYNC_IDLE;
         r.rc_sy <= pmf_pkg::SYNC_IDLE;
         r.sec_sy <= pmf_pkg::SYNC_IDLE;
         r.scl_f <= 1'b1;
         r.sda_f <= 1'b1;
         r.rc_f <= 1'b1;
         r.sec_f <= 1'b1;
         r.cfg <= pmf_pkg::CFG_DEF;
         r.usr <= pmf_pkg::CFG_DEF;
         r.pg_oe <= 1'b1;
         r.pg_o <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ==========================================================================
   // Outputs
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign sda_o = 1'b0;
   assign sda_oe = r.sda_oe;
   assign fault_alert_line_o = 1'b0;
   assign fault_alert_line_oe = r.alert;
   assign output_ok_indicator_o = r.pg_o;
   assign output_ok_indicator_oe = r.pg_oe;
   assign output_enable = r.out_on;
   assign vout_target = r.vout_tgt;

endmodule

//--- inc/pmf_pkg.sv
package pmf_pkg;

   // ==========================================================================
   // Bus commands
   localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_STORE_DEFAULT_ALL = 8'h11;
   localparam logic [7:0] CMD_RESTORE_DEFAULT_ALL = 8'h12;
   localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
   localparam logic [7:0] CMD_SMBALERT_MASK = 8'h1b;
   localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
   localparam logic [7:0] CMD_VOUT_TRIM = 8'h22;
   localparam logic [7:0] CMD_VIN_ON = 8'h35;
   localparam logic [7:0] CMD_VIN_OFF = 8'h36;
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;
   localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b;
   localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
   localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
   localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
   localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
   localparam logic [7:0] CMD_READ_VIN = 8'h88;
   localparam logic [7:0] CMD_READ_VOUT = 8'h8b;
   localparam logic [7:0] CMD_READ_IOUT = 8'h8c;
   localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
   localparam logic [7:0] CMD_READ_DUTY = 8'h94;
   localparam logic [7:0] CMD_READ_FREQ = 8'h95;
   localparam logic [7:0] CMD_TEMP_SOURCE = 8'hdc;

   // ==========================================================================
   // Working configuration slots and their factory values
   localparam int NCFG = 6;
   localparam logic [2:0] CFG_ONOFF = 3'h0;
   localparam logic [2:0] CFG_VOUT_CMD = 3'h1;
   localparam logic [2:0] CFG_VOUT_TRIM = 3'h2;
   localparam logic [2:0] CFG_VIN_ON = 3'h3;
   localparam logic [2:0] CFG_VIN_OFF = 3'h4;
   localparam logic [2:0] CFG_TSRC = 3'h5;
   localparam logic [2:0] IDX_NONE = 3'h7;
   localparam logic [NCFG-1:0][15:0] CFG_DEF = {
      16'h0000, 16'h0020, 16'h0024, 16'h0000, 16'h1800, 16'h0017};
   localparam int ONOFF_SEC_POL_BIT = 1;

   // Status byte slots: vout, iout, input, temperature, cml, mfr.
   localparam int NST = 6;
   localparam int ST_CML = 4;

   // ==========================================================================
   // Register bus map (byte addresses)
   localparam logic [7:0] A_TEL_LAST = 8'h18;
   localparam logic [7:0] A_FAULT_EVT = 8'h1c;
   localparam logic [7:0] A_FAULT_EVT2 = 8'h20;
   localparam logic [7:0] A_HWOPT = 8'h24;
   localparam logic [7:0] A_STATE = 8'h28;

   // ==========================================================================
   // Timing and identity
   localparam int CLK_MHZ = 250;
   localparam int STORE_TIME_US = 5000;
   localparam int STORE_CYC = STORE_TIME_US * CLK_MHZ;
   // Arbitrary default target address.
   localparam logic [6:0] DEV_ADDR_DEF = 7'h40;
   localparam logic [2:0] SYNC_IDLE = 3'h7;

   typedef enum logic [2:0] {P_IDLE, P_ADDR, P_CMD, P_WR, P_RD} pmf_pst_e;

endpackage

//--- verif/pmf_host.sv
`timescale 1ns/1ps
module pmf_host #(
   parameter logic [6:0] ADDR = pmf_pkg::DEV_ADDR_DEF
) (
   output logic scl,
   output wire sda,
   input wire logic dev_pull
);
   logic hdrv = 1'b0;
   initial scl = 1'b1;
   // The line has a pull-up, so it is low only while some side pulls it.
   assign sda = !(hdrv || dev_pull);
   // One bit takes a fixed 80 ns link period; the target never stretches the clock.
   task automatic bit_io(input logic b, output logic r);
      hdrv = !b;
      #20 scl = 1'b1;
      #20 r = sda;
      #20 scl = 1'b0;
      #20;
   endtask
   task automatic start;
      hdrv = 1'b0;
      #20 scl = 1'b1;
      #20 hdrv = 1'b1;
      #20 scl = 1'b0;
      #20;
   endtask
   task automatic stop;
      hdrv = 1'b1;
      #20 scl = 1'b1;
      #20 hdrv = 1'b0;
      #80;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ak = !r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
   // No packet error code byte is appended, since the target checks none.
   task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d, output logic ak);
      logic a;
      start();
      wbyte({ADDR, 1'b0}, ak);
      wbyte(c, a);
      for (int i = 0; i < n; i++) wbyte(d[8*i +: 8], a);
      stop();
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      logic a;
      start();
      wbyte({ADDR, 1'b0}, a);
      wbyte(c, a);
      start();
      wbyte({ADDR, 1'b1}, a);
      rbyte(1'b0, d[7:0]);
      rbyte(1'b1, d[15:8]);
      stop();
   endtask
endmodule

//--- verif/pmf_mon_sva.sv
`timescale 1ns/1ps
module pmf_mon_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic fault_alert_line_o,
   input wire logic fault_alert_line_oe,
   input wire logic primary_remote_onoff_pin,
   input wire logic output_ok_indicator_o,
   input wire logic output_ok_indicator_oe,
   input wire logic output_enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_next:
      assert property (ce && psel && !penable |=> pready)
      else $error("no answer in access cycle");
   a_ready_pulse:
      assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_pair:
      assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_open_drain:
      assert property (sda_o == 1'b0 && fault_alert_line_o == 1'b0)
      else $error("open-drain level not low");
   a_alert_clear:
      assert property ($fell(fault_alert_line_oe) |-> $past(scl_i, 5) || output_enable)
      else $error("alert released early");
   a_pin_off:
      assert property (primary_remote_onoff_pin [*6] |=> !output_enable)
      else $error("output on with pin open");
   a_ok_on:
      assert property ((output_enable && output_ok_indicator_oe) [*2] |-> !output_ok_indicator_o)
      else $error("output ok missing");
   a_ok_off:
      assert property ((!output_enable && output_ok_indicator_oe) [*2] |-> output_ok_indicator_o)
      else $error("output ok while off");
endmodule

//--- verif/pmf_mon_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pmf_mon_tb;
   localparam int SC = 400;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rc_pin = 1, sec_drv = 1;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic pready, pslverr, scl, sda_oe, al_oe, ok_o, ok_oe, oen;
   wire sda;
   wire sec_line = ok_oe ? ok_o : sec_drv;
   logic [15:0] vt;
   int fails = 0, checked = 0;
   always #2 pclk = ~pclk;
   pmf_mon #(.STORE_CYC(SC)) i_pmf_mon (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe,
      .fault_alert_line_o(), .fault_alert_line_oe(al_oe), .primary_remote_onoff_pin(rc_pin),
      .output_ok_indicator_i(sec_line), .output_ok_indicator_o(ok_o),
      .output_ok_indicator_oe(ok_oe), .output_enable(oen), .vout_target(vt));
   pmf_host i_pmf_host (.scl, .sda, .dev_pull(sda_oe));
   // ==========
   // Bus helpers.
   task automatic w(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x,
                      input logic xe);
      int n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 50) fails++;
      if (!wr) `CHK(prdata, x)
      `CHK(pslverr, xe)
      psel <= 0;
      penable <= 0;
   endtask
   task automatic sw(input logic [7:0] c, input int n, input logic [15:0] d);
      logic ak;
      i_pmf_host.wr(c, n, d, ak);
      w(4);
   endtask
   task automatic sr(input logic [7:0] c, input logic [15:0] m, input logic [15:0] x);
      logic [15:0] v;
      i_pmf_host.rd(c, v);
      `CHK(v & m, x)
   endtask
   // ==========
   // Scenarios.
   task automatic t_tel;
      logic [7:0] c [7] = '{8'h88, 8'h8b, 8'h8c, 8'h8d, 8'h8d, 8'h95, 8'h94};
      `CHK(vt, 16'h1800)
      sr(8'h35, 16'hffff, 16'h0024);
      for (int i = 0; i < 7; i++) apb(1, 8'(4 * i), {24'h5a, 8'(i)}, 0, 0);
      for (int i = 0; i < 7; i++) begin
         if (i == 4) sw(8'hdc, 1, 16'h0001);
         sr(c[i], 16'hffff, {8'h5a, 8'(i)});
      end
      apb(0, 8'h40, 0, 0, 1);
   endtask
   task automatic t_alert;
      apb(1, 8'h1c, 32'h8000, 0, 0);
      w(4);
      `CHK(al_oe, 1'b1)
      sr(8'h7b, 16'h00ff, 16'h0080);
      sr(8'h79, 16'hf8ff, 16'h4850);
      `CHK(al_oe, 1'b1)
      sw(8'h03, 0, 0);
      `CHK(al_oe, 1'b0)
      sr(8'h7b, 16'h00ff, 16'h0000);
      sw(8'h1b, 2, 16'hff7b);
      apb(1, 8'h1c, 32'h8000, 0, 0);
      w(4);
      `CHK(al_oe, 1'b0)
      sr(8'h78, 16'h00ff, 16'h0050);
      sw(8'hc0, 0, 0);
      `CHK(al_oe, 1'b1)
      sr(8'h7e, 16'h00ff, 16'h0080);
      sw(8'h03, 0, 0);
   endtask
   task automatic t_nvm;
      logic ak;
      sw(8'h21, 2, 16'h1234);
      sw(8'h22, 2, 16'h0010);
      `CHK(vt, 16'h1244)
      sw(8'h11, 0, 0);
      w(SC);
      sw(8'h15, 0, 0);
      i_pmf_host.wr(8'h21, 2, 16'h0000, ak);
      `CHK(ak, 1'b0)
      w(SC);
      `CHK(vt, 16'h1244)
      sr(8'h78, 16'h0080, 16'h0080);
      sw(8'h12, 0, 0);
      `CHK(vt, 16'h1800)
      sw(8'h03, 0, 0);
   endtask
   task automatic t_onoff;
      logic [15:0] v [5] = '{16'h22, 16'h1f, 16'h22, 16'h24, 16'h23};
      logic e [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      apb(1, 8'h1c, 32'h0100_0000, 0, 0);
      rc_pin <= 1'b0;
      w(12);
      `CHK(oen, 1'b1)
      `CHK(al_oe, 1'b0)
      for (int i = 0; i < 5; i++) begin
         apb(1, 8'h00, {16'h0, v[i]}, 0, 0);
         w(4);
         `CHK(oen, e[i])
      end
      rc_pin <= 1'b1;
      w(12);
      `CHK(oen, 1'b0)
      rc_pin <= 1'b0;
      apb(1, 8'h24, 32'h1, 0, 0);
      w(12);
      `CHK(ok_oe, 1'b0)
      `CHK(oen, 1'b1)
      sec_drv <= 1'b0;
      w(12);
      `CHK(oen, 1'b0)
      sw(8'h02, 2, 16'h0015);
      w(8);
      `CHK(oen, 1'b1)
   endtask
   // ==========
   // Run control.
   task automatic finish_test;
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      w(20);
      presetn <= 1;
      w(12);
      t_tel();
      t_alert();
      t_nvm();
      t_onoff();
      finish_test();
   end
   initial begin
      #300us;
      fails++;
      finish_test();
   end
endmodule
bind pmf_mon pmf_mon_sva i_pmf_mon_sva (.pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr,
   .scl_i, .sda_o, .fault_alert_line_o, .fault_alert_line_oe, .primary_remote_onoff_pin,
   .output_ok_indicator_o, .output_ok_indicator_oe, .output_enable);
